// file: core/acq_pkg.sv
// Shared constants, types and register map of the acquisition capture block
package acq_pkg;
  localparam int SAMPLE_W = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int AUX_PULSE_NS = 40;
  localparam int AUX_PULSE_CYC = (AUX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_MODE = 12'h004;
  localparam logic [11:0] REG_ADC_RATE = 12'h008;
  localparam logic [11:0] REG_WAVE_RATE = 12'h00c;
  localparam logic [11:0] REG_REC_LEN = 12'h010;
  localparam logic [11:0] REG_PRE_LEN = 12'h014;
  localparam logic [11:0] REG_MEAN_DEPTH = 12'h018;
  localparam logic [11:0] REG_BURST = 12'h01c;
  localparam logic [11:0] REG_TIME_SCALE = 12'h020;
  localparam logic [11:0] REG_ROLL_THRESH = 12'h024;
  localparam logic [11:0] REG_STATUS = 12'h028;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_CLEAR_BIT = 2;
  localparam int CTRL_ROLL_BIT = 3;
  localparam int MODE_ACQ_LSB = 0;
  localparam int MODE_INTERP_LSB = 4;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ROLL_BIT = 3;
  localparam int STAT_HIST_LSB = 8;
  localparam int STAT_BURST_LSB = 16;

  localparam logic [15:0] ADC_RATE_RST = 16'h0001;
  localparam logic [15:0] WAVE_RATE_RST = 16'h0001;
  localparam logic [15:0] REC_LEN_RST = 16'h0100;
  localparam logic [15:0] PRE_LEN_RST = 16'h0080;
  localparam logic [7:0] MEAN_DEPTH_RST = 8'h10;
  localparam logic [7:0] BURST_RST = 8'h01;
  localparam logic [15:0] ROLL_THRESH_RST = 16'h1000;

  typedef enum logic [2:0] {
    ACQ_SAMPLE = 3'h0,
    ACQ_MINMAX = 3'h1,
    ACQ_BOXCAR = 3'h2,
    ACQ_MEAN = 3'h3,
    ACQ_BOXCAR_THEN_RECORD_MEAN = 3'h4,
    ACQ_ENVELOPE = 3'h5,
    ACQ_MINMAX_BASED_ENVELOPE = 3'h6,
    ACQ_BOXCAR_BASED_ENVELOPE = 3'h7
  } acq_mode_t;

  typedef enum logic [1:0] {
    INTERP_SINC = 2'h0,
    INTERP_LINEAR = 2'h1,
    INTERP_HOLD = 2'h2
  } interp_t;

  localparam acq_mode_t ACQ_RST = ACQ_SAMPLE;
  localparam interp_t INTERP_RST = INTERP_SINC;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'b000,
    CAP_PRE = 3'b001,
    CAP_POST = 3'b011,
    CAP_SHOW = 3'b010,
    CAP_ROLL = 3'b110
  } cap_state_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] value;
    logic signed [SAMPLE_W-1:0] floor;
    logic signed [SAMPLE_W-1:0] roof;
  } rec_point_t;
endpackage

// file: core/acq_capture.sv
// Acquisition decimation, interpolation, record capture and record arithmetic
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Plain mode below ADC rate keeps one sample of each group of n.
// - Above ADC rate, extra points are inserted by the chosen interpolation.
// - Min/max mode outputs group minimum and maximum, drops the rest.
// - Boxcar mode outputs the mean of each group of n.
// - Mean mode outputs per-point mean of current and preceding records.
// - A programmable depth sets how many records join the mean.
// - Clear discards history; averaging restarts from the next record.
// - Combined mode: boxcar within record, then mean across records.
// - Envelope: plain-sampled records, per-point floor and roof tracked.
// - Min/max envelope: min/max records, extremes over all records.
// - Boxcar envelope: boxcar records, per-point floor and roof tracked.
// - Sinc-style interpolation using neighbours is selected after reset.
// - Linear interpolation puts points on the line between two samples.
// - Hold interpolation repeats the sample that starts the interval.
// - While armed, capture continuously and fill the pretrigger part.
// - After trigger, fill posttrigger part, stop, then present record.
// - After an accepted trigger, further triggers ignored until complete.
// - Single start acquires exactly the programmed record count, then stops.
// - Auto scroll enabled and time scale at threshold or slower: scroll.
// - Scroll delivers samples as they arrive, without a full record.
// - Scroll forces automatic record length.
// - Each accepted trigger pulses aux output and lights the indicator.
module acq_capture #(
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_valid,
  input wire logic signed [acq_pkg::SAMPLE_W-1:0] adc_data,
  input wire logic trig_in,
  output logic rec_valid,
  output logic [$clog2(DEPTH)-1:0] rec_index,
  output acq_pkg::rec_point_t rec_point,
  output logic roll_valid,
  output logic signed [acq_pkg::SAMPLE_W-1:0] roll_data,
  output logic aux_pulse,
  output logic trig_led
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = acq_pkg::SAMPLE_W;
  localparam int ACC_W = SW + 8;

  if (DEPTH < 4 || (1 << AW) != DEPTH)
  begin : g_depth_check
    $error("DEPTH must be a power of two of at least 4");
  end

  typedef logic signed [SW-1:0] smp_t;

  function automatic logic [15:0] rate_ratio(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] q;
    q = (b == 16'h0000) ? 16'h0001 : a / b;
    return (q == 16'h0000) ? 16'h0001 : q;
  endfunction

  function automatic smp_t clip(input logic signed [63:0] v);
    if (v > 64'sd32767)
      return 16'sh7fff;
    else if (v < -64'sd32768)
      return 16'sh8000;
    else
      return smp_t'(v);
  endfunction

  function automatic smp_t smin(input smp_t a, input smp_t b);
    return (a < b) ? a : b;
  endfunction

  function automatic smp_t smax(input smp_t a, input smp_t b);
    return (a > b) ? a : b;
  endfunction

  // Cubic through four neighbours stands in for the band-limited curve
  function automatic smp_t interp_point(input acq_pkg::interp_t how, input smp_t s0,
      input smp_t s1, input smp_t s2, input smp_t s3, input logic [15:0] k,
      input logic [15:0] m);
    logic signed [63:0] t;
    logic signed [63:0] a;
    logic signed [63:0] b;
    logic signed [63:0] c;
    logic signed [63:0] p;
    t = $signed(64'({k, 8'h00} / {8'h00, m}));
    a = -s0 + 3 * s1 - 3 * s2 + s3;
    b = 2 * s0 - 5 * s1 + 4 * s2 - s3;
    c = s2 - s0;
    case (how)
      acq_pkg::INTERP_HOLD: p = s1;
      acq_pkg::INTERP_LINEAR: p = s1 + (((s2 - s1) * t) >>> 8);
      default: p = ((((((a * t) >>> 8) + b) * t >>> 8) + c) * t >>> 8) + 2 * s1 >>> 1;
    endcase
    return clip(p);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register file
  logic run_q;
  logic roll_en_q;
  acq_pkg::acq_mode_t acq_q;
  acq_pkg::interp_t interp_q;
  logic [15:0] adc_rate_q;
  logic [15:0] wave_rate_q;
  logic [15:0] rec_len_q;
  logic [15:0] pre_len_q;
  logic [7:0] mean_depth_q;
  logic [7:0] burst_q;
  logic [15:0] time_scale_q;
  logic [15:0] roll_thresh_q;
  logic [31:0] prdata_q;
  logic [7:0] burst_left_q;
  logic [7:0] hist_cnt_q;
  acq_pkg::cap_state_t state_q;
  logic wr_fire;
  logic single_go;
  logic clear_go;
  logic mapped;
  logic [31:0] rd_mux;

  assign wr_fire = psel && penable && pwrite && mapped;
  assign single_go = wr_fire && paddr == acq_pkg::REG_CTRL && pwdata[acq_pkg::CTRL_SINGLE_BIT];
  assign clear_go = wr_fire && paddr == acq_pkg::REG_CTRL && pwdata[acq_pkg::CTRL_CLEAR_BIT];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      acq_pkg::REG_CTRL: rd_mux = {28'h0, roll_en_q, 2'b00, run_q};
      acq_pkg::REG_MODE: rd_mux = {26'h0, interp_q, 1'b0, acq_q};
      acq_pkg::REG_ADC_RATE: rd_mux = {16'h0, adc_rate_q};
      acq_pkg::REG_WAVE_RATE: rd_mux = {16'h0, wave_rate_q};
      acq_pkg::REG_REC_LEN: rd_mux = {16'h0, rec_len_q};
      acq_pkg::REG_PRE_LEN: rd_mux = {16'h0, pre_len_q};
      acq_pkg::REG_MEAN_DEPTH: rd_mux = {24'h0, mean_depth_q};
      acq_pkg::REG_BURST: rd_mux = {24'h0, burst_q};
      acq_pkg::REG_TIME_SCALE: rd_mux = {16'h0, time_scale_q};
      acq_pkg::REG_ROLL_THRESH: rd_mux = {16'h0, roll_thresh_q};
      acq_pkg::REG_STATUS:
        rd_mux = {8'h0, burst_left_q, hist_cnt_q, 4'h0, state_q == acq_pkg::CAP_ROLL,
                  state_q};
      default: mapped = 1'b0;
    endcase
  end

  // Read data is latched in the setup phase so it is steady for the access phase
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_mux;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_q <= 1'b0;
      roll_en_q <= 1'b0;
      acq_q <= acq_pkg::ACQ_RST;
      interp_q <= acq_pkg::INTERP_RST;
      adc_rate_q <= acq_pkg::ADC_RATE_RST;
      wave_rate_q <= acq_pkg::WAVE_RATE_RST;
      rec_len_q <= acq_pkg::REC_LEN_RST;
      pre_len_q <= acq_pkg::PRE_LEN_RST;
      mean_depth_q <= acq_pkg::MEAN_DEPTH_RST;
      burst_q <= acq_pkg::BURST_RST;
      time_scale_q <= 16'h0000;
      roll_thresh_q <= acq_pkg::ROLL_THRESH_RST;
    end
    else if (wr_fire)
    begin
      case (paddr)
        acq_pkg::REG_CTRL:
        begin
          run_q <= pwdata[acq_pkg::CTRL_RUN_BIT];
          roll_en_q <= pwdata[acq_pkg::CTRL_ROLL_BIT];
        end
        acq_pkg::REG_MODE:
        begin
          acq_q <= acq_pkg::acq_mode_t'(pwdata[acq_pkg::MODE_ACQ_LSB +: 3]);
          interp_q <= acq_pkg::interp_t'(pwdata[acq_pkg::MODE_INTERP_LSB +: 2]);
        end
        acq_pkg::REG_ADC_RATE: adc_rate_q <= pwdata[15:0];
        acq_pkg::REG_WAVE_RATE: wave_rate_q <= pwdata[15:0];
        acq_pkg::REG_REC_LEN: rec_len_q <= pwdata[15:0];
        acq_pkg::REG_PRE_LEN: pre_len_q <= pwdata[15:0];
        acq_pkg::REG_MEAN_DEPTH: mean_depth_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        acq_pkg::REG_BURST: burst_q <= pwdata[7:0];
        acq_pkg::REG_TIME_SCALE: time_scale_q <= pwdata[15:0];
        acq_pkg::REG_ROLL_THRESH: roll_thresh_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decimation and interpolation into one point stream
  logic [15:0] n_dec;
  logic [15:0] m_int;
  logic interp_on;
  logic [15:0] grp_cnt_q;
  smp_t keep_q;
  smp_t min_q;
  smp_t max_q;
  logic signed [31:0] sum_q;
  smp_t cur_min;
  smp_t cur_max;
  logic signed [31:0] cur_sum;
  smp_t s0_q;
  smp_t s1_q;
  smp_t s2_q;
  smp_t s3_q;
  logic [15:0] ip_k_q;
  logic ip_busy_q;
  logic pend_q;
  smp_t pend_data_q;
  logic pt_valid_q;
  smp_t pt_q;
  logic grp_end;

  assign n_dec = rate_ratio(adc_rate_q, wave_rate_q);
  assign m_int = rate_ratio(wave_rate_q, adc_rate_q);
  assign interp_on = wave_rate_q > adc_rate_q;
  assign grp_end = adc_valid && !interp_on && grp_cnt_q == n_dec - 16'h0001;
  assign cur_min = (grp_cnt_q == 16'h0000) ? adc_data : smin(min_q, adc_data);
  assign cur_max = (grp_cnt_q == 16'h0000) ? adc_data : smax(max_q, adc_data);
  assign cur_sum = (grp_cnt_q == 16'h0000) ? 32'(adc_data) : sum_q + 32'(adc_data);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      grp_cnt_q <= 16'h0000;
      keep_q <= '0;
      min_q <= '0;
      max_q <= '0;
      sum_q <= 32'sh0;
    end
    else if (adc_valid && !interp_on)
    begin
      grp_cnt_q <= grp_end ? 16'h0000 : grp_cnt_q + 16'h0001;
      if (grp_cnt_q == 16'h0000)
        keep_q <= adc_data;
      min_q <= cur_min;
      max_q <= cur_max;
      sum_q <= cur_sum;
    end
  end

  // Interpolated points fill one ADC interval; the ADC must not outpace m cycles
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s0_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      ip_k_q <= 16'h0000;
      ip_busy_q <= 1'b0;
    end
    else if (adc_valid && interp_on)
    begin
      {s0_q, s1_q, s2_q, s3_q} <= {s1_q, s2_q, s3_q, adc_data};
      ip_k_q <= 16'h0000;
      ip_busy_q <= 1'b1;
    end
    else if (ip_busy_q)
    begin
      ip_k_q <= ip_k_q + 16'h0001;
      ip_busy_q <= ip_k_q + 16'h0001 < m_int;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pt_valid_q <= 1'b0;
      pt_q <= '0;
      pend_q <= 1'b0;
      pend_data_q <= '0;
    end
    else
    begin
      pt_valid_q <= 1'b0;
      pend_q <= 1'b0;
      if (pend_q)
      begin
        pt_valid_q <= 1'b1;
        pt_q <= pend_data_q;
      end
      else if (ip_busy_q && !(adc_valid && interp_on))
      begin
        pt_valid_q <= 1'b1;
        pt_q <= interp_point(interp_q, s0_q, s1_q, s2_q, s3_q, ip_k_q, m_int);
      end
      else if (grp_end)
      begin
        pt_valid_q <= 1'b1;
        case (acq_q)
          acq_pkg::ACQ_MINMAX, acq_pkg::ACQ_MINMAX_BASED_ENVELOPE:
          begin
            pt_q <= cur_min;
            pend_q <= 1'b1;
            pend_data_q <= cur_max;
          end
          acq_pkg::ACQ_BOXCAR, acq_pkg::ACQ_BOXCAR_THEN_RECORD_MEAN,
          acq_pkg::ACQ_BOXCAR_BASED_ENVELOPE:
            pt_q <= clip(64'(cur_sum / $signed({16'h0, n_dec})));
          default: pt_q <= (grp_cnt_q == 16'h0000) ? adc_data : keep_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger input: three flops, a change counts when the last two agree
  logic [2:0] trig_sync_q;
  logic trig_level_q;
  logic trig_edge;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trig_sync_q <= 3'b000;
      trig_level_q <= 1'b0;
    end
    else
    begin
      trig_sync_q <= {trig_sync_q[1:0], trig_in};
      if (trig_sync_q[1] == trig_sync_q[2])
        trig_level_q <= trig_sync_q[2];
    end
  end

  assign trig_edge = trig_sync_q[1] && trig_sync_q[2] && !trig_level_q;

  //////////////////////////////////////////////////////////////////////////
  // Record capture
  smp_t raw_mem [DEPTH];
  logic signed [ACC_W-1:0] sum_mem [DEPTH];
  smp_t lo_mem [DEPTH];
  smp_t hi_mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] start_q;
  logic [AW:0] fill_q;
  logic [AW:0] show_idx_q;
  logic [AW:0] eff_len;
  logic [AW:0] pre_len;
  logic [AW:0] req_len;
  logic roll_active;
  logic armed;
  logic trig_ok;
  logic show_last;
  logic [$clog2(acq_pkg::AUX_PULSE_CYC+1)-1:0] aux_cnt_q;

  assign req_len = (rec_len_q > 16'(DEPTH)) ? (AW+1)'(DEPTH) : (AW+1)'(rec_len_q);
  assign roll_active = roll_en_q && time_scale_q >= roll_thresh_q;
  assign eff_len = roll_active ? (AW+1)'(DEPTH) :
      ((req_len < (AW+1)'(2)) ? (AW+1)'(2) : req_len);
  assign pre_len = (pre_len_q >= 16'(eff_len)) ? eff_len - (AW+1)'(1) : (AW+1)'(pre_len_q);
  assign armed = run_q || burst_left_q != 8'h00;
  assign trig_ok = state_q == acq_pkg::CAP_PRE && fill_q >= pre_len && trig_edge;
  assign show_last = state_q == acq_pkg::CAP_SHOW && show_idx_q == eff_len - (AW+1)'(1);

  always_ff @(posedge clock)
  begin
    if (pt_valid_q && (state_q == acq_pkg::CAP_PRE || state_q == acq_pkg::CAP_POST))
      raw_mem[wr_ptr_q] <= pt_q;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= acq_pkg::CAP_IDLE;
      wr_ptr_q <= '0;
      start_q <= '0;
      fill_q <= '0;
      show_idx_q <= '0;
    end
    else
    begin
      case (state_q)
        acq_pkg::CAP_IDLE:
        begin
          fill_q <= '0;
          if (roll_active && run_q)
            state_q <= acq_pkg::CAP_ROLL;
          else if (armed || single_go)
            state_q <= acq_pkg::CAP_PRE;
        end
        acq_pkg::CAP_PRE:
        begin
          if (pt_valid_q)
          begin
            wr_ptr_q <= wr_ptr_q + AW'(1);
            if (fill_q < pre_len)
              fill_q <= fill_q + (AW+1)'(1);
          end
          if (roll_active || !armed)
            state_q <= acq_pkg::CAP_IDLE;
          else if (trig_ok)
          begin
            state_q <= acq_pkg::CAP_POST;
            start_q <= wr_ptr_q - AW'(pre_len);
            fill_q <= pre_len;
          end
        end
        acq_pkg::CAP_POST:
        begin
          if (pt_valid_q)
          begin
            wr_ptr_q <= wr_ptr_q + AW'(1);
            fill_q <= fill_q + (AW+1)'(1);
            if (fill_q == eff_len - (AW+1)'(1))
            begin
              state_q <= acq_pkg::CAP_SHOW;
              show_idx_q <= '0;
            end
          end
        end
        acq_pkg::CAP_SHOW:
        begin
          show_idx_q <= show_idx_q + (AW+1)'(1);
          if (show_last)
          begin
            fill_q <= '0;
            state_q <= (armed && !(burst_left_q == 8'h01 && !run_q)) ?
                acq_pkg::CAP_PRE : acq_pkg::CAP_IDLE;
          end
        end
        acq_pkg::CAP_ROLL:
          if (!roll_active || !run_q)
            state_q <= acq_pkg::CAP_IDLE;
        default: state_q <= acq_pkg::CAP_IDLE;
      endcase
    end
  end

  // A burst counts down once per presented record
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      burst_left_q <= 8'h00;
    else if (single_go)
      burst_left_q <= burst_q;
    else if (show_last && burst_left_q != 8'h00)
      burst_left_q <= burst_left_q - 8'h01;
  end

  // Scroll output bypasses the record and forwards each point immediately
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      roll_valid <= 1'b0;
      roll_data <= '0;
    end
    else
    begin
      roll_valid <= pt_valid_q && state_q == acq_pkg::CAP_ROLL;
      if (pt_valid_q)
        roll_data <= pt_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aux_cnt_q <= '0;
      trig_led <= 1'b0;
    end
    else if (trig_ok)
    begin
      aux_cnt_q <= ($bits(aux_cnt_q))'(acq_pkg::AUX_PULSE_CYC);
      trig_led <= 1'b1;
    end
    else
    begin
      if (aux_cnt_q != '0)
        aux_cnt_q <= aux_cnt_q - ($bits(aux_cnt_q))'(1);
      if (state_q == acq_pkg::CAP_IDLE || state_q == acq_pkg::CAP_PRE)
        trig_led <= 1'b0;
    end
  end

  assign aux_pulse = aux_cnt_q != '0;

  //////////////////////////////////////////////////////////////////////////
  // Record arithmetic across acquisitions
  logic [AW-1:0] pi;
  smp_t x;
  logic signed [ACC_W-1:0] sum_new;
  logic signed [ACC_W-1:0] div;
  smp_t lo_new;
  smp_t hi_new;
  logic fresh;
  logic is_mean;
  logic is_env;

  assign pi = AW'(show_idx_q);
  assign x = raw_mem[start_q + pi];
  assign fresh = hist_cnt_q == 8'h00;
  assign is_mean = acq_q == acq_pkg::ACQ_MEAN || acq_q == acq_pkg::ACQ_BOXCAR_THEN_RECORD_MEAN;
  assign is_env = acq_q == acq_pkg::ACQ_ENVELOPE || acq_q == acq_pkg::ACQ_MINMAX_BASED_ENVELOPE ||
      acq_q == acq_pkg::ACQ_BOXCAR_BASED_ENVELOPE;
  assign lo_new = fresh ? x : smin(lo_mem[pi], x);
  assign hi_new = fresh ? x : smax(hi_mem[pi], x);

  // Past the depth the window becomes a running mean, which needs no record store
  always_comb
  begin
    if (fresh)
    begin
      sum_new = ACC_W'(x);
      div = ACC_W'(1);
    end
    else if (hist_cnt_q < mean_depth_q)
    begin
      sum_new = sum_mem[pi] + ACC_W'(x);
      div = ACC_W'(hist_cnt_q) + ACC_W'(1);
    end
    else
    begin
      sum_new = sum_mem[pi] - sum_mem[pi] / $signed(ACC_W'(mean_depth_q)) + ACC_W'(x);
      div = ACC_W'(mean_depth_q);
    end
  end

  always_ff @(posedge clock)
  begin
    if (state_q == acq_pkg::CAP_SHOW)
    begin
      sum_mem[pi] <= sum_new;
      lo_mem[pi] <= lo_new;
      hi_mem[pi] <= hi_new;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      hist_cnt_q <= 8'h00;
    else if (clear_go)
      hist_cnt_q <= 8'h00;
    else if (show_last && hist_cnt_q != 8'hff)
      hist_cnt_q <= hist_cnt_q + 8'h01;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rec_valid <= 1'b0;
      rec_index <= '0;
      rec_point <= '0;
    end
    else
    begin
      rec_valid <= state_q == acq_pkg::CAP_SHOW;
      rec_index <= pi;
      if (is_mean)
      begin
        rec_point.value <= smp_t'(sum_new / div);
        rec_point.floor <= smp_t'(sum_new / div);
        rec_point.roof <= smp_t'(sum_new / div);
      end
      else
      begin
        rec_point.value <= x;
        rec_point.floor <= is_env ? lo_new : x;
        rec_point.roof <= is_env ? hi_new : x;
      end
    end
  end
endmodule

// file: verif/acq_capture_props.sv
// Checker: port timing relations of the acquisition capture block
`timescale 1ns/100ps
module acq_capture_props #(
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_valid,
  input wire logic signed [acq_pkg::SAMPLE_W-1:0] adc_data,
  input wire logic trig_in,
  input wire logic rec_valid,
  input wire logic [$clog2(DEPTH)-1:0] rec_index,
  input wire acq_pkg::rec_point_t rec_point,
  input wire logic roll_valid,
  input wire logic signed [acq_pkg::SAMPLE_W-1:0] roll_data,
  input wire logic aux_pulse,
  input wire logic trig_led
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  slverr_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  aux_width_a: assert property ($rose(aux_pulse) |-> aux_pulse [*5] ##1 !aux_pulse)
    else $error("aux pulse width wrong");
  aux_led_a: assert property ($rose(aux_pulse) |-> ##[0:1] trig_led)
    else $error("trigger indicator not lit");
  show_no_trig_a: assert property (rec_valid |-> !$rose(aux_pulse))
    else $error("trigger accepted during record output");
  index_step_a: assert property (rec_valid && $past(rec_valid) |->
    rec_index == $past(rec_index) + 1'b1) else $error("record index skipped");
  index_start_a: assert property ($rose(rec_valid) |-> rec_index == '0)
    else $error("record does not start at index zero");
  roll_excl_a: assert property (roll_valid |-> !rec_valid)
    else $error("scroll point during record output");
  cover property ($rose(rec_valid));
  cover property ($rose(aux_pulse));
  cover property (roll_valid);
endmodule

// file: verif/adc_stream.sv
// ADC sample stream model: a rising ramp at fixed spacing
`timescale 1ns/100ps
module adc_stream #(
  parameter int GAP = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  output logic adc_valid,
  output logic signed [acq_pkg::SAMPLE_W-1:0] adc_data
);
  logic [7:0] cnt_q;
  logic signed [acq_pkg::SAMPLE_W-1:0] val_q;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      cnt_q <= '0;
      val_q <= '0;
      adc_valid <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
      adc_valid <= cnt_q == 8'(GAP - 1);
      if (adc_valid)
        val_q <= val_q + 16'sh0001;
    end
  // Stale data is inverted off the strobe so a late sampler gets caught
  assign adc_data = adc_valid ? val_q : ~val_q;
endmodule

// file: verif/testbench.sv
// Testbench: APB setup, ramp stream, record and scroll checks
`timescale 1ns/100ps
module testbench;
  logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, trig_in = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, adc_valid, rec_valid, roll_valid, aux_pulse, trig_led;
  logic aux_q = 0;
  logic signed [15:0] adc_data, roll_data;
  logic signed [15:0] rl, rl_prev, fl, rf;
  logic signed [15:0] pts [0:7];
  logic [7:0] rec_index;
  acq_pkg::rec_point_t rec_point;
  int n_errors = 0, check_count = 0, n_pts = 0, n_trig = 0, n_roll = 0, m;
  always #4 clock = ~clock;
  acq_capture acq_capture_i (.*);
  adc_stream adc_stream_i (.*);
  always @(posedge clock)
  begin
    aux_q <= aux_pulse;
    if (rec_valid)
    begin
      pts[rec_index[2:0]] <= rec_point.value;
      fl <= rec_point.floor;
      rf <= rec_point.roof;
    end
    if (roll_valid)
    begin
      rl <= roll_data;
      rl_prev <= rl;
    end
    n_pts <= n_pts + int'(rec_valid);
    n_trig <= n_trig + int'(aux_pulse && !aux_q);
    n_roll <= n_roll + int'(roll_valid);
  end
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    t = 0;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
    if (t == 50)
    begin
      chk(0, 1);
      stop_test();
    end
  endtask
  // Trigger rises every 60 cycles: some land in post fill and must be ignored
  task automatic capture(input int mode, input int recs);
    int t, p0, g0;
    apb(1, acq_pkg::REG_MODE, mode);
    apb(1, acq_pkg::REG_BURST, recs);
    p0 = n_pts;
    g0 = n_trig;
    apb(1, acq_pkg::REG_CTRL, 32'h2);
    for (t = 0; t < 4000 && n_pts - p0 < 8 * recs; t++)
    begin
      @(posedge clock);
      trig_in <= (t % 60) > 40;
    end
    trig_in <= 0;
    repeat (300) @(posedge clock);
    chk(n_pts - p0, 8 * recs);
    chk(n_trig - g0, recs);
    apb(0, acq_pkg::REG_STATUS, 0);
    chk(rd[2:0], 0);
    $display("capture mode %0d records %0d done", mode, recs);
    if (t == 4000)
    begin
      chk(0, 1);
      stop_test();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1;
    apb(0, acq_pkg::REG_MODE, 0);
    chk(rd, 0);
    apb(0, acq_pkg::REG_REC_LEN, 0);
    chk(rd, 32'h100);
    apb(0, 12'h0fc, 0);
    chk(err, 1);
    $display("reset values done");
    apb(1, acq_pkg::REG_ADC_RATE, 4);
    apb(1, acq_pkg::REG_WAVE_RATE, 1);
    apb(1, acq_pkg::REG_REC_LEN, 8);
    apb(1, acq_pkg::REG_PRE_LEN, 4);
    // Ramp step 1, n = 4: any of these modes advances by 4 per group
    for (m = 0; m < 3; m++)
    begin
      capture(m, 1);
      for (int i = 0; i < 8 - (m == 1 ? 2 : 1); i++)
        chk(16'(pts[i + (m == 1 ? 2 : 1)] - pts[i]), 4);
    end
    capture(0, 2);
    // After a clear the first mean record is the record itself
    apb(1, acq_pkg::REG_CTRL, 32'h4);
    capture(3, 1);
    for (int i = 0; i < 7; i++)
      chk(16'(pts[i + 1] - pts[i]), 4);
    // Rising ramp: the roof is the newest record, the floor an older one
    capture(5, 1);
    chk(rf, pts[7]);
    chk(fl < pts[7], 1);
    apb(1, acq_pkg::REG_TIME_SCALE, 32'h1000);
    apb(1, acq_pkg::REG_CTRL, 32'h9);
    repeat (200) @(posedge clock);
    chk(n_roll > 0, 1);
    apb(0, acq_pkg::REG_STATUS, 0);
    chk(rd[3], 1);
    chk(16'(rl - rl_prev), 4);
    apb(1, acq_pkg::REG_CTRL, 0);
    $display("scroll done");
    // Two hold points per ADC sample, so every second point steps by one
    apb(1, acq_pkg::REG_ADC_RATE, 1);
    apb(1, acq_pkg::REG_WAVE_RATE, 2);
    capture(32'h20, 1);
    for (int i = 0; i < 6; i++)
      chk(16'(pts[i + 2] - pts[i]), 1);
    stop_test();
  end
endmodule
bind acq_capture acq_capture_props #(.DEPTH(DEPTH)) acq_capture_props_i (.*);
